// file: hdl/rco_pkg.sv
// package: register map, field layout and types of the reference clock output
package rco_pkg;

   // ------------------------------------------------------------
   // bus and register map
   // ------------------------------------------------------------
   localparam int          APB_AW        = 12;
   localparam int          NUM_PINS      = 8;
   localparam int          PIN_SEL_W     = 3;
   localparam int          CNT_W         = 15;
   localparam int          DIV_W         = 4;
   localparam logic [11:0] CTRL_OFFSET   = 12'h000;
   localparam logic [11:0] PIN_OFFSET    = 12'h004;

   // ------------------------------------------------------------
   // control register fields and reset values
   // ------------------------------------------------------------
   localparam int          CTRL_EN_BIT   = 15;
   localparam int          CTRL_RIS_BIT  = 13;
   localparam int          CTRL_SRC_BIT  = 12;
   localparam int          CTRL_DIV_LSB  = 8;
   localparam logic [15:0] CTRL_WR_MASK  = 16'hBF00;
   localparam logic [15:0] CTRL_RESET    = 16'h0000;
   localparam logic [2:0]  PIN_RESET     = 3'h0;
   localparam logic [3:0]  DIV_PASS      = 4'h0;
   localparam logic        SRC_SYSTEM    = 1'b1;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef struct packed {
      logic              psel;
      logic              penable;
      logic              pwrite;
      logic [APB_AW-1:0] paddr;
      logic [31:0]       pwdata;
   } rco_apb_req_t;

   typedef struct packed {
      logic             ref_out_enable;
      logic             ref_run_in_sleep;
      logic             ref_source_select;
      logic [DIV_W-1:0] ref_divider_select;
   } rco_ctrl_t;

endpackage

// file: hdl/rco_divider.sv
// power-of-two divider of the selected reference source
`timescale 1ns/1ps
module rco_divider
   import rco_pkg::*;
(
   // clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             rst_n_i,
   // control
   input  wire logic             run_i,
   input  wire logic             src_sel_i,
   input  wire logic [DIV_W-1:0] div_sel_i,
   input  wire logic             alt_src_i,
   // divided output
   output logic                  ref_o
);

   typedef struct packed {
      logic             sys_phase;
      logic             src_prev;
      logic [CNT_W-1:0] cnt;
      logic             out;
   } rco_div_state_t;

   rco_div_state_t   st_q;
   rco_div_state_t   st_d;
   logic             src_lvl;
   logic             tick;
   logic [CNT_W-1:0] half_m1;

   // ------------------------------------------------------------
   // source selection and divide
   // ------------------------------------------------------------
   // system clock source seen as a level toggling every cycle
   assign src_lvl = (src_sel_i == SRC_SYSTEM) ? st_q.sys_phase : alt_src_i;
   assign tick    = src_lvl & ~st_q.src_prev;
   assign half_m1 = (CNT_W'(1) << (div_sel_i - DIV_W'(1))) - CNT_W'(1);

   always_comb begin
      st_d           = st_q;
      st_d.sys_phase = ~st_q.sys_phase;
      st_d.src_prev  = src_lvl;
      // stopped: counter and output held low
      if (!run_i) begin
         st_d.cnt = '0;
         st_d.out = 1'b0;
      end else if (div_sel_i == DIV_PASS) begin
         st_d.cnt = '0;
         st_d.out = src_lvl;
      // divide by two to the code
      end else if (tick) begin
         if (st_q.cnt >= half_m1) begin
            st_d.cnt = '0;
            st_d.out = ~st_q.out;
         end else begin
            st_d.cnt = st_q.cnt + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign ref_o = st_q.out;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_div_pass;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      run_i && div_sel_i == DIV_PASS |=> ref_o == $past(src_lvl);
   endproperty
   a_div_pass: assert property (p_div_pass)
      else $error("pass-through output does not follow source");

   property p_div_toggle;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      run_i && div_sel_i != DIV_PASS && tick && st_q.cnt >= half_m1
         |=> ref_o != $past(ref_o) && st_q.cnt == '0;
   endproperty
   a_div_toggle: assert property (p_div_toggle)
      else $error("divider did not toggle at terminal count");

   property p_div_hold;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      !run_i |=> !ref_o && st_q.cnt == '0;
   endproperty
   a_div_hold: assert property (p_div_hold)
      else $error("stopped divider still running");

endmodule

// file: hdl/rco_pin_route.sv
// routes the reference clock onto one selected remappable pin
`timescale 1ns/1ps
module rco_pin_route
   import rco_pkg::*;
(
   // clock and reset
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_n_i,
   // source
   input  wire logic                 enable_i,
   input  wire logic                 ref_i,
   input  wire logic [PIN_SEL_W-1:0] pin_sel_i,
   // pins
   output logic [NUM_PINS-1:0]       pin_o,
   output logic [NUM_PINS-1:0]       pin_oe_o
);

   typedef struct packed {
      logic [NUM_PINS-1:0] pin;
      logic [NUM_PINS-1:0] oe;
   } rco_route_state_t;

   rco_route_state_t st_q;
   rco_route_state_t st_d;

   // ------------------------------------------------------------
   // per-pin selection
   // ------------------------------------------------------------
   // one remappable pin chosen
   for (genvar i = 0; i < NUM_PINS; i++) begin : g_pin
      assign st_d.oe[i]  = enable_i && (pin_sel_i == PIN_SEL_W'(i));
      assign st_d.pin[i] = st_d.oe[i] & ref_i;
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign pin_o    = st_q.pin;
   assign pin_oe_o = st_q.oe;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_route;
      @(posedge core_clk_i) disable iff (!rst_n_i)
      enable_i |=> pin_oe_o == (NUM_PINS'(1) << $past(pin_sel_i))
         && pin_o == (pin_oe_o & {NUM_PINS{$past(ref_i)}});
   endproperty
   a_route: assert property (p_route)
      else $error("reference not on the selected pin");

endmodule

// file: hdl/rco_top.sv
// reference clock output generator with APB control register
//
// The placing of the registers and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module rco_top
   import rco_pkg::*;
(
   // clock and reset
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_n_i,
   // apb slave
   input  wire rco_apb_req_t         apb_req_i,
   output logic [31:0]               prdata_o,
   output logic                      pready_o,
   output logic                      pslverr_o,
   // system
   input  wire logic                 sleep_i,
   input  wire logic                 alt_src_i,
   // remappable pins
   output logic [NUM_PINS-1:0]       pin_o,
   output logic [NUM_PINS-1:0]       pin_oe_o
);

   typedef struct packed {
      rco_ctrl_t            ctrl;
      logic [PIN_SEL_W-1:0] pin_sel;
      logic                 pready;
      logic                 pslverr;
      logic [31:0]          prdata;
   } rco_state_t;

   rco_state_t  st_q;
   rco_state_t  st_d;
   logic [1:0]  rst_sync_q;
   logic        rst_n;
   logic        access;
   logic        hit_ctrl;
   logic        hit_pin;
   logic        run;
   logic        ref_clk;
   logic        pass_sys;
   logic        pass_alt;
   logic [15:0] ctrl_word;

   // ------------------------------------------------------------
   // reset release
   // ------------------------------------------------------------
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync_q <= 2'h0;
      end else begin
         rst_sync_q <= {rst_sync_q[0], 1'b1};
      end
   end

   assign rst_n = rst_sync_q[1];

   // ------------------------------------------------------------
   // register decode
   // ------------------------------------------------------------
   assign access   = apb_req_i.psel && apb_req_i.penable;
   assign hit_ctrl = apb_req_i.paddr == CTRL_OFFSET;
   assign hit_pin  = apb_req_i.paddr == PIN_OFFSET;

   assign ctrl_word = {st_q.ctrl.ref_out_enable, 1'b0,
                       st_q.ctrl.ref_run_in_sleep,
                       st_q.ctrl.ref_source_select,
                       st_q.ctrl.ref_divider_select, 8'h00};

   always_comb begin
      st_d         = st_q;
      st_d.pready  = 1'b0;
      st_d.pslverr = 1'b0;
      // one wait state: data captured, ready raised next cycle
      if (access && !st_q.pready) begin
         st_d.pready  = 1'b1;
         st_d.pslverr = !(hit_ctrl || hit_pin);
         st_d.prdata  = 32'h0000_0000;
         if (!apb_req_i.pwrite && hit_ctrl) begin
            st_d.prdata = {16'h0000, ctrl_word};
         end else if (!apb_req_i.pwrite && hit_pin) begin
            st_d.prdata = {{(32-PIN_SEL_W){1'b0}}, st_q.pin_sel};
         end
      end
      // write lands at the edge where ready is sampled
      if (access && st_q.pready && apb_req_i.pwrite) begin
         if (hit_ctrl) begin
            st_d.ctrl.ref_out_enable     = apb_req_i.pwdata[CTRL_EN_BIT];
            st_d.ctrl.ref_run_in_sleep   = apb_req_i.pwdata[CTRL_RIS_BIT];
            st_d.ctrl.ref_source_select  = apb_req_i.pwdata[CTRL_SRC_BIT];
            // divider written whether the output is on or off
            st_d.ctrl.ref_divider_select =
               apb_req_i.pwdata[CTRL_DIV_LSB +: DIV_W];
         end else if (hit_pin) begin
            st_d.pin_sel = apb_req_i.pwdata[PIN_SEL_W-1:0];
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         st_q.ctrl    <= '{ref_out_enable:     CTRL_RESET[CTRL_EN_BIT],
                           ref_run_in_sleep:   CTRL_RESET[CTRL_RIS_BIT],
                           ref_source_select:  CTRL_RESET[CTRL_SRC_BIT],
                           ref_divider_select: CTRL_RESET[CTRL_DIV_LSB +: DIV_W]};
         st_q.pin_sel <= PIN_RESET;
         st_q.pready  <= 1'b0;
         st_q.pslverr <= 1'b0;
         st_q.prdata  <= 32'h0000_0000;
      end else begin
         st_q <= st_d;
      end
   end

   assign prdata_o  = st_q.prdata;
   assign pready_o  = st_q.pready;
   assign pslverr_o = st_q.pslverr;

   // ------------------------------------------------------------
   // output gating
   // ------------------------------------------------------------
   // enable gates the output
   // run on in Sleep when allowed
   // otherwise stop in Sleep, resume on wake
   assign run = st_q.ctrl.ref_out_enable
                && (!sleep_i || st_q.ctrl.ref_run_in_sleep);

   rco_divider u_divider (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n),
      .run_i      (run),
      .src_sel_i  (st_q.ctrl.ref_source_select),
      .div_sel_i  (st_q.ctrl.ref_divider_select),
      .alt_src_i  (alt_src_i),
      .ref_o      (ref_clk)
   );

   rco_pin_route u_route (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n),
      .enable_i   (run),
      .ref_i      (ref_clk),
      .pin_sel_i  (st_q.pin_sel),
      .pin_o      (pin_o),
      .pin_oe_o   (pin_oe_o)
   );

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_rsvd_zero;
      @(posedge core_clk_i) disable iff (!rst_n)
      access && !st_q.pready && !apb_req_i.pwrite && hit_ctrl
         |=> prdata_o[14] == 1'b0 && prdata_o[7:0] == 8'h00 && pready_o;
   endproperty
   a_rsvd_zero: assert property (p_rsvd_zero)
      else $error("reserved control bits not zero");

   property p_reset_zero;
      @(posedge core_clk_i) disable iff (!rst_n)
      !$past(rst_n) |-> st_q.ctrl == '0 && pin_oe_o == '0;
   endproperty
   a_reset_zero: assert property (p_reset_zero)
      else $error("control not cleared after reset");

   property p_oe_off;
      @(posedge core_clk_i) disable iff (!rst_n)
      !st_q.ctrl.ref_out_enable |=> pin_oe_o == '0;
   endproperty
   a_oe_off: assert property (p_oe_off)
      else $error("pin driven while output disabled");

   property p_sleep_stop;
      @(posedge core_clk_i) disable iff (!rst_n)
      sleep_i && !st_q.ctrl.ref_run_in_sleep ##1
      sleep_i && !st_q.ctrl.ref_run_in_sleep |=> pin_o == '0 && pin_oe_o == '0;
   endproperty
   a_sleep_stop: assert property (p_sleep_stop)
      else $error("output active in Sleep without run-in-sleep");

   property p_sleep_run;
      @(posedge core_clk_i) disable iff (!rst_n)
      sleep_i && st_q.ctrl.ref_run_in_sleep && st_q.ctrl.ref_out_enable
         |=> pin_oe_o == (NUM_PINS'(1) << $past(st_q.pin_sel));
   endproperty
   a_sleep_run: assert property (p_sleep_run)
      else $error("output stopped in Sleep despite run-in-sleep");

   // ------------------------------------------------------------
   // register and pin assertions
   // ------------------------------------------------------------
   // pass-through conditions seen by the divider
   assign pass_sys = run && st_q.ctrl.ref_divider_select == DIV_PASS
                     && st_q.ctrl.ref_source_select == SRC_SYSTEM;
   assign pass_alt = run && st_q.ctrl.ref_divider_select == DIV_PASS
                     && st_q.ctrl.ref_source_select != SRC_SYSTEM;

   property p_wr_enable;
      @(posedge core_clk_i) disable iff (!rst_n)
      access && st_q.pready && apb_req_i.pwrite && hit_ctrl
         |=> st_q.ctrl.ref_out_enable == $past(apb_req_i.pwdata[CTRL_EN_BIT]);
   endproperty
   a_wr_enable: assert property (p_wr_enable)
      else $error("enable bit not taken from write");

   property p_wr_sleep;
      @(posedge core_clk_i) disable iff (!rst_n)
      access && st_q.pready && apb_req_i.pwrite && hit_ctrl
         |=> st_q.ctrl.ref_run_in_sleep == $past(apb_req_i.pwdata[CTRL_RIS_BIT]);
   endproperty
   a_wr_sleep: assert property (p_wr_sleep)
      else $error("run-in-sleep bit not taken from write");

   property p_wr_source;
      @(posedge core_clk_i) disable iff (!rst_n)
      access && st_q.pready && apb_req_i.pwrite && hit_ctrl
         |=> st_q.ctrl.ref_source_select == $past(apb_req_i.pwdata[CTRL_SRC_BIT]);
   endproperty
   a_wr_source: assert property (p_wr_source)
      else $error("source select not taken from write");

   property p_wr_divider;
      @(posedge core_clk_i) disable iff (!rst_n)
      access && st_q.pready && apb_req_i.pwrite && hit_ctrl
         |=> st_q.ctrl.ref_divider_select == $past(apb_req_i.pwdata[CTRL_DIV_LSB +: DIV_W]);
   endproperty
   a_wr_divider: assert property (p_wr_divider)
      else $error("divider field not taken from write");

   property p_rd_fields;
      @(posedge core_clk_i) disable iff (!rst_n)
      access && !st_q.pready && !apb_req_i.pwrite && hit_ctrl
         |=> prdata_o[CTRL_EN_BIT] == $past(st_q.ctrl.ref_out_enable)
            && prdata_o[CTRL_DIV_LSB +: DIV_W] == $past(st_q.ctrl.ref_divider_select);
   endproperty
   a_rd_fields: assert property (p_rd_fields)
      else $error("control read does not show fields");

   property p_rd_upper;
      @(posedge core_clk_i) disable iff (!rst_n)
      access && !st_q.pready && !apb_req_i.pwrite && hit_ctrl
         |=> prdata_o[31:16] == 16'h0000;
   endproperty
   a_rd_upper: assert property (p_rd_upper)
      else $error("upper half of control read not zero");

   property p_run_on;
      @(posedge core_clk_i) disable iff (!rst_n)
      st_q.ctrl.ref_out_enable && !sleep_i
         |=> pin_oe_o == (NUM_PINS'(1) << $past(st_q.pin_sel));
   endproperty
   a_run_on: assert property (p_run_on)
      else $error("enabled output not driven on selected pin");

   property p_wake;
      @(posedge core_clk_i) disable iff (!rst_n)
      $fell(sleep_i) && st_q.ctrl.ref_out_enable |=> pin_oe_o != '0;
   endproperty
   a_wake: assert property (p_wake)
      else $error("output did not resume after wake-up");

   property p_oe_onehot;
      @(posedge core_clk_i) disable iff (!rst_n)
      pin_oe_o != '0 |-> $onehot(pin_oe_o);
   endproperty
   a_oe_onehot: assert property (p_oe_onehot)
      else $error("more than one pin driven");

   property p_pin_masked;
      @(posedge core_clk_i) disable iff (!rst_n)
      pin_o != '0 |-> (pin_o & ~pin_oe_o) == '0;
   endproperty
   a_pin_masked: assert property (p_pin_masked)
      else $error("level on a pin that is not driven");

   property p_sys_pass;
      @(posedge core_clk_i) disable iff (!rst_n)
      pass_sys ##1 pass_sys ##1 pass_sys |=> pin_o != $past(pin_o);
   endproperty
   a_sys_pass: assert property (p_sys_pass)
      else $error("system source not passed to the pin");

   property p_alt_pass;
      @(posedge core_clk_i) disable iff (!rst_n)
      pass_alt ##1 pass_alt |=> (|pin_o) == $past(alt_src_i, 2);
   endproperty
   a_alt_pass: assert property (p_alt_pass)
      else $error("alternate source not passed to the pin");

   property p_pin_sel_wr;
      @(posedge core_clk_i) disable iff (!rst_n)
      access && st_q.pready && apb_req_i.pwrite && hit_pin
         |=> st_q.pin_sel == $past(apb_req_i.pwdata[PIN_SEL_W-1:0]);
   endproperty
   a_pin_sel_wr: assert property (p_pin_sel_wr)
      else $error("pin select not taken from write");

endmodule

// file: testbench/rco_clk_sink.sv
// consumer of the reference clock: measures high time on one pin
`timescale 1ns/1ps
module rco_clk_sink
   import rco_pkg::*;
(
   // clock
   input  wire logic                 core_clk_i,
   // pins
   input  wire logic [NUM_PINS-1:0]  pin_i,
   input  wire logic [NUM_PINS-1:0]  pin_oe_i,
   input  wire logic [PIN_SEL_W-1:0] watch_i,
   // measurement
   output int                        falls_o,
   output int                        high_o
);
   logic wire_lvl;
   logic last_lvl;
   logic last_oe;
   int   run_cnt;

   // undriven line wanders, never holds its last level
   assign wire_lvl = pin_oe_i[watch_i] ? pin_i[watch_i] : ~last_lvl;

   initial begin
      falls_o  = 0;
      high_o   = 0;
      run_cnt  = 0;
      last_lvl = 1'b0;
      last_oe  = 1'b0;
   end

   always @(posedge core_clk_i) begin
      last_lvl <= wire_lvl;
      last_oe  <= pin_oe_i[watch_i];
      if (!pin_oe_i[watch_i]) begin
         run_cnt <= 0;
      end else if (wire_lvl) begin
         run_cnt <= run_cnt + 1;
      end else if (last_lvl && last_oe) begin
         high_o  <= run_cnt;
         falls_o <= falls_o + 1;
         run_cnt <= 0;
      end
   end
endmodule

// file: testbench/reference_clock_output_divider_tb.sv
// self-checking bench for the reference clock output block
`timescale 1ns/1ps
module reference_clock_output_divider_tb;
   import rco_pkg::*;

   logic                 core_clk_i = 1'b0;
   logic                 rst_n_i    = 1'b0;
   rco_apb_req_t         apb_req    = '0;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   logic                 sleep      = 1'b0;
   logic                 alt_src    = 1'b0;
   logic [NUM_PINS-1:0]  pin;
   logic [NUM_PINS-1:0]  pin_oe;
   logic [PIN_SEL_W-1:0] watch      = '0;
   int                   falls_seen;
   int                   high_seen;
   int                   fails      = 0;
   int                   check_count = 0;
   int                   alt_cnt    = 0;
   logic [31:0]          rd;
   logic                 err;

   always #5 core_clk_i = ~core_clk_i;

   // alternate source: high 3 cycles, low 3 cycles
   always @(posedge core_clk_i) begin
      alt_cnt <= (alt_cnt == 5) ? 0 : alt_cnt + 1;
      alt_src <= (alt_cnt < 3);
   end

   rco_top DUT (
      .core_clk_i (core_clk_i),
      .rst_n_i    (rst_n_i),
      .apb_req_i  (apb_req),
      .prdata_o   (prdata),
      .pready_o   (pready),
      .pslverr_o  (pslverr),
      .sleep_i    (sleep),
      .alt_src_i  (alt_src),
      .pin_o      (pin),
      .pin_oe_o   (pin_oe)
   );

   rco_clk_sink sink (
      .core_clk_i (core_clk_i),
      .pin_i      (pin),
      .pin_oe_i   (pin_oe),
      .watch_i    (watch),
      .falls_o    (falls_seen),
      .high_o     (high_seen)
   );

   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic final_report();
      if (fails == 0 && check_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         $display("mismatch %s expected %0h seen %0h", what, exp, got);
         fails++;
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge core_clk_i);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
      @(posedge core_clk_i);
      apb_req.penable <= 1'b1;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) chk("pready", 32'h1, 32'h0);
      rd  = prdata;
      err = pslverr;
      apb_req <= '0;
   endtask

   task automatic wait_falls(input int n);
      int start;
      int k;
      start = falls_seen;
      k = 0;
      while (falls_seen < start + n && k < 70000) begin
         @(posedge core_clk_i);
         k++;
      end
      if (k >= 70000) chk("falls", n, falls_seen - start);
   endtask

   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs();
      apb(0, CTRL_OFFSET, 32'h0);
      chk("ctrl reset", {16'h0, CTRL_RESET}, rd);
      apb(0, PIN_OFFSET, 32'h0);
      chk("pin reset", {29'h0, PIN_RESET}, rd);
      chk("oe reset", 32'h0, {24'h0, pin_oe});
      apb(1, CTRL_OFFSET, 32'hFFFF_7FFF);
      apb(0, CTRL_OFFSET, 32'h0);
      chk("ctrl reserved", 32'h0000_3F00, rd);
      apb(1, CTRL_OFFSET, 32'h0);
      apb(1, 12'h008, 32'hFFFF_FFFF);
      chk("unmapped wr err", 32'h1, {31'h0, err});
      apb(0, 12'h008, 32'h0);
      chk("unmapped rd", 32'h0, rd);
      chk("unmapped rd err", 32'h1, {31'h0, err});
   endtask

   // system source toggles each cycle, so high time is 2^code cycles
   task automatic t_divider(input logic [3:0] code, input logic [2:0] sel);
      logic [31:0] c;
      c = {16'h0, 4'h1, code, 8'h00};
      apb(1, PIN_OFFSET, {29'h0, sel});
      watch <= sel;
      apb(1, CTRL_OFFSET, c);
      apb(1, CTRL_OFFSET, c | 32'h8000);
      repeat (3) @(posedge core_clk_i);
      chk("oe on", {24'h0, 8'h01 << sel}, {24'h0, pin_oe});
      apb(0, PIN_OFFSET, 32'h0);
      chk("pin readback", {29'h0, sel}, rd);
      apb(0, CTRL_OFFSET, 32'h0);
      chk("ctrl readback", c | 32'h8000, rd);
      wait_falls((code == 4'hF) ? 1 : 2);
      chk("high", 32'h1 << code, high_seen);
      apb(1, CTRL_OFFSET, c);
      repeat (3) @(posedge core_clk_i);
      chk("oe off", 32'h0, {24'h0, pin_oe});
   endtask

   task automatic t_sleep();
      apb(1, PIN_OFFSET, 32'h2);
      watch <= 3'h2;
      apb(1, CTRL_OFFSET, 32'h1200);
      apb(1, CTRL_OFFSET, 32'h9200);
      sleep <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      chk("oe sleep stop", 32'h0, {24'h0, pin_oe});
      sleep <= 1'b0;
      repeat (4) @(posedge core_clk_i);
      chk("oe wake", 32'h4, {24'h0, pin_oe});
      apb(1, CTRL_OFFSET, 32'h1200);
      apb(1, CTRL_OFFSET, 32'h3200);
      apb(1, CTRL_OFFSET, 32'hB200);
      sleep <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      chk("oe sleep run", 32'h4, {24'h0, pin_oe});
      wait_falls(2);
      chk("high sleep", 32'h4, high_seen);
      sleep <= 1'b0;
      apb(1, CTRL_OFFSET, 32'h3200);
   endtask

   task automatic t_alt();
      apb(1, CTRL_OFFSET, 32'h0);
      apb(1, CTRL_OFFSET, 32'h8000);
      wait_falls(2);
      chk("high alt div1", 32'h3, high_seen);
      apb(1, CTRL_OFFSET, 32'h0);
      apb(1, CTRL_OFFSET, 32'h0100);
      apb(1, CTRL_OFFSET, 32'h8100);
      wait_falls(2);
      chk("high alt div2", 32'h6, high_seen);
      apb(1, CTRL_OFFSET, 32'h0100);
   endtask

   task automatic t_reset();
      apb(1, CTRL_OFFSET, 32'h8100);
      rst_n_i <= 1'b0;
      repeat (2) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      chk("oe after reset", 32'h0, {24'h0, pin_oe});
      apb(0, CTRL_OFFSET, 32'h0);
      chk("ctrl after reset", {16'h0, CTRL_RESET}, rd);
   endtask

   initial begin
      repeat (90000) @(posedge core_clk_i);
      fails++;
      final_report();
   end

   initial begin
      repeat (8) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      t_regs();
      for (int i = 0; i < 8; i++) begin
         t_divider(i[3:0], i[2:0]);
      end
      t_divider(4'hF, 3'h7);
      t_sleep();
      t_alt();
      t_reset();
      final_report();
   end
endmodule
